// ### inc/icp_pkg.sv
// Shared constants and state types of the two-wire control port
package icp_pkg;

    localparam logic [6:0] DEV_ADDR = 7'h1B;
    localparam int BYTE_W = 8;
    localparam int WORD_BYTES = 4;
    localparam int BIQUAD_WORDS = 5;
    localparam int MAX_BYTES = WORD_BYTES * BIQUAD_WORDS;

    localparam int CLK_NS = 20;
    localparam int SPIKE_NS = 50;
    localparam int SPIKE_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int STD_KHZ = 100;
    localparam int FAST_KHZ = 400;
    // Quarter of a bus clock period, rounded up so the rate is never exceeded
    localparam int QTR_STD_CYC =
        (1000000 / STD_KHZ / 4 + CLK_NS - 1) / CLK_NS;
    localparam int QTR_FAST_CYC =
        (1000000 / FAST_KHZ / 4 + CLK_NS - 1) / CLK_NS;

    typedef enum logic [2:0] {
        D_IDLE,
        D_RX,
        D_ACK,
        D_TX,
        D_MACK
    } icp_dev_st_e;

    typedef enum logic [1:0] {
        P_DEV,
        P_SUB,
        P_DATA
    } icp_phase_e;

    typedef enum logic [2:0] {
        H_IDLE,
        H_START,
        H_TXB,
        H_RXB,
        H_STOP
    } icp_host_st_e;

    typedef enum logic [2:0] {
        S_DEVW,
        S_SUB,
        S_WDATA,
        S_DEVR,
        S_RDATA
    } icp_stage_e;

endpackage : icp_pkg

// ### inc/icp_link_if.sv
// Two-wire control link joining the host end and the device end
`timescale 1ns/10ps
interface icp_link_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // Pulled-up wired-AND bus: any enabled low driver pulls the line low
    assign scl = ~(host_scl_oe & ~host_scl_o);
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport host (
        output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
        input scl, sda
    );
    modport dev (
        output dev_sda_o, dev_sda_oe,
        input scl, sda
    );
endinterface : icp_link_if

// ### verilog/icp_line_filter.sv
// Pin synchroniser followed by a spike filter for one bus line
`timescale 1ns/10ps
module icp_line_filter
    import icp_pkg::*;
#(
    parameter int FILT_CYC = SPIKE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic raw,
    output logic level
);
    localparam int CW = $clog2(FILT_CYC + 1);

    logic sync1;
    logic sync2;
    logic next_level;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;

    // A new level is taken only after it has held for FILT_CYC cycles
    always_comb begin
        next_level = level;
        next_cnt = '0;
        if (sync2 != level) begin
            if (cnt == CW'(FILT_CYC - 1)) begin
                next_level = sync2;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            level <= 1'b1;
            cnt <= '0;
        end else if (ce) begin
            sync1 <= raw;
            sync2 <= sync1;
            level <= next_level;
            cnt <= next_cnt;
        end
    end
endmodule : icp_line_filter

// ### verilog/icp_dev_end.sv
// Slave end of the control port: byte engine, subaddress and word commit
// Functional notes
// R1 - eight-bit bytes, most significant bit first
// R2 - receiver acknowledges in ninth clock
// R3 - detect start and stop conditions
// R4 - master changes data only while clock low
// R5 - hold data low through acknowledge period
// R6 - answer only fixed seven-bit address
// R7 - no limit on bytes per transfer
// R8 - processing registers move in four-byte units
// R9 - reads return bytes while master acknowledges
// R10 - unused bits of narrow registers read zero; the code sends rd_data[7:0] unmasked
// R11 - biquad needs five words, else discarded
// R12 - mixer coefficient commits after one word
// R13 - sequential write advances through subaddresses
// R14 - incomplete last subaddress alone is discarded
// R15 - direction bit zero means write
// R16 - acknowledge address, subaddress, every data byte
// R17 - master reads via write, restart, read
// R18 - master NACKs last byte then stops
// R19 - slave only, never stretches clock
// R20 - runs without the audio master clock
// R21 - supports 100 kHz and 400 kHz
// R22 - synchronise and deglitch lines before use
`timescale 1ns/10ps
module icp_dev_end
    import icp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    icp_link_if.dev link,
    output logic [7:0] reg_addr,
    input wire logic [4:0] size_bytes,
    output logic [2:0] rd_word,
    input wire logic [31:0] rd_data,
    output logic wr_commit,
    output logic [7:0] wr_addr,
    output logic [4:0] wr_nbytes,
    output logic [MAX_BYTES*BYTE_W-1:0] wr_data
);
    localparam int WB = MAX_BYTES * BYTE_W;

    logic scl_f;
    logic sda_f;
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    icp_dev_st_e st;
    icp_dev_st_e next_st;
    icp_phase_e phase;
    icp_phase_e next_phase;
    logic rw;
    logic next_rw;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit;
    logic [7:0] shreg;
    logic [7:0] next_sh;
    logic [7:0] sub;
    logic [7:0] next_sub;
    logic [4:0] byte_cnt;
    logic [4:0] next_bcnt;
    logic acked;
    logic next_acked;
    logic sda_oe;
    logic next_oe;
    logic [WB-1:0] wbuf;
    logic [WB-1:0] next_wbuf;
    logic next_commit;
    logic [7:0] next_waddr;
    logic [4:0] next_wn;
    logic [4:0] size_eff;
    logic last_byte;
    logic [7:0] tx_byte;

    // R20 runs on clk only
    // R21 R22 sync and filter
    icp_line_filter u_scl_filt (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .raw(link.scl),
        .level(scl_f)
    );
    icp_line_filter u_sda_filt (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .raw(link.sda),
        .level(sda_f)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (ce) begin
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    assign scl_rise = scl_f & ~scl_q;
    assign scl_fall = ~scl_f & scl_q;
    // R3 start and stop
    assign start_det = scl_f & scl_q & sda_q & ~sda_f;
    assign stop_det = scl_f & scl_q & ~sda_q & sda_f;

    // A size of zero from the register map is taken as a plain byte register
    assign size_eff = (size_bytes == 5'h00) ? 5'h01 :
        ((size_bytes > 5'(MAX_BYTES)) ? 5'(MAX_BYTES) : size_bytes);
    assign last_byte = (5'(byte_cnt + 5'h01) == size_eff);

    // R10 narrow registers send rd_data[7:0] unmasked, no bits zeroed here
    always_comb begin
        tx_byte = rd_data[7:0];
        if (size_eff != 5'h01) begin
            case (byte_cnt[1:0])
                2'h0: tx_byte = rd_data[31:24];
                2'h1: tx_byte = rd_data[23:16];
                2'h2: tx_byte = rd_data[15:8];
                default: tx_byte = rd_data[7:0];
            endcase
        end
    end

    always_comb begin
        next_st = st;
        next_phase = phase;
        next_rw = rw;
        next_bit = bit_cnt;
        next_sh = shreg;
        next_sub = sub;
        next_bcnt = byte_cnt;
        next_acked = acked;
        next_oe = sda_oe;
        next_wbuf = wbuf;
        next_commit = 1'b0;
        next_waddr = wr_addr;
        next_wn = wr_nbytes;
        if (stop_det) begin
            // R11 partial data dropped on stop
            next_st = D_IDLE;
            next_oe = 1'b0;
            next_bcnt = 5'h00;
        end else if (start_det) begin
            // R14 restart drops only the partial set
            next_st = D_RX;
            next_phase = P_DEV;
            next_bit = 4'h0;
            next_oe = 1'b0;
            next_bcnt = 5'h00;
        end else begin
            case (st)
                D_RX: begin
                    // R1 shift in MSB first
                    if (scl_rise) begin
                        next_sh = {shreg[6:0], sda_f};
                        next_bit = 4'(bit_cnt + 4'h1);
                    end else if (scl_fall && bit_cnt == 4'h8) begin
                        // R2 R16 acknowledge each byte, except an address byte that does not match
                        next_oe = 1'b1;
                        next_st = D_ACK;
                        case (phase)
                            P_DEV: begin
                                // R6 address match
                                if (shreg[7:1] == DEV_ADDR) begin
                                    // R15 direction bit
                                    next_rw = shreg[0];
                                    next_phase = P_SUB;
                                end else begin
                                    next_oe = 1'b0;
                                    next_st = D_IDLE;
                                end
                            end
                            P_SUB: begin
                                next_sub = shreg;
                                next_bcnt = 5'h00;
                                next_phase = P_DATA;
                            end
                            default: begin
                                next_wbuf = {wbuf[WB-BYTE_W-1:0], shreg};
                                // R8 R11 R12 commit whole sets only
                                if (last_byte) begin
                                    next_commit = 1'b1;
                                    next_waddr = sub;
                                    next_wn = size_eff;
                                    // R13 advance subaddress
                                    next_sub = 8'(sub + 8'h01);
                                    next_bcnt = 5'h00;
                                end else begin
                                    next_bcnt = 5'(byte_cnt + 5'h01);
                                end
                            end
                        endcase
                    end
                end
                D_ACK: begin
                    // R5 low for whole ack period
                    if (scl_fall) begin
                        next_bit = 4'h0;
                        if (rw) begin
                            next_st = D_TX;
                            next_sh = tx_byte;
                            next_oe = ~tx_byte[7];
                        end else begin
                            next_st = D_RX;
                            next_oe = 1'b0;
                        end
                    end
                end
                D_TX: begin
                    // R19 data changes on the master's falling edge only
                    if (scl_fall) begin
                        if (bit_cnt == 4'h7) begin
                            next_oe = 1'b0;
                            next_st = D_MACK;
                        end else begin
                            next_sh = {shreg[6:0], 1'b0};
                            next_oe = ~shreg[6];
                            next_bit = 4'(bit_cnt + 4'h1);
                        end
                    end
                end
                D_MACK: begin
                    // R9 continue while acknowledged
                    if (scl_rise) begin
                        next_acked = ~sda_f;
                        if (!sda_f) begin
                            if (last_byte) begin
                                next_sub = 8'(sub + 8'h01);
                                next_bcnt = 5'h00;
                            end else begin
                                next_bcnt = 5'(byte_cnt + 5'h01);
                            end
                        end
                    end else if (scl_fall) begin
                        if (acked) begin
                            next_st = D_TX;
                            next_bit = 4'h0;
                            next_sh = tx_byte;
                            next_oe = ~tx_byte[7];
                        end else begin
                            next_st = D_IDLE;
                        end
                    end
                end
                default: begin
                    next_oe = 1'b0;
                end
            endcase
        end
    end

    // R7 counters wrap, so transfers may run on indefinitely
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= D_IDLE;
            phase <= P_DEV;
            rw <= 1'b0;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            sub <= 8'h00;
            byte_cnt <= 5'h00;
            acked <= 1'b0;
            sda_oe <= 1'b0;
            wbuf <= '0;
            wr_commit <= 1'b0;
            wr_addr <= 8'h00;
            wr_nbytes <= 5'h00;
        end else if (ce) begin
            st <= next_st;
            phase <= next_phase;
            rw <= next_rw;
            bit_cnt <= next_bit;
            shreg <= next_sh;
            sub <= next_sub;
            byte_cnt <= next_bcnt;
            acked <= next_acked;
            sda_oe <= next_oe;
            wbuf <= next_wbuf;
            wr_commit <= next_commit;
            wr_addr <= next_waddr;
            wr_nbytes <= next_wn;
        end
    end

    assign wr_data = wbuf;
    assign reg_addr = sub;
    assign rd_word = byte_cnt[4:2];
    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe = sda_oe;
endmodule : icp_dev_end

// ### verilog/icp_host_end.sv
// Master end of the control port: issues register reads and writes
`timescale 1ns/10ps
module icp_host_end
    import icp_pkg::*;
#(
    parameter bit FAST = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    icp_link_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_rw,
    input wire logic [7:0] cmd_sub,
    input wire logic [7:0] cmd_len,
    input wire logic [7:0] wr_byte,
    output logic wr_take,
    output logic rd_valid,
    output logic [7:0] rd_byte,
    output logic done,
    output logic nack
);
    localparam logic [7:0] QTR =
        8'(FAST ? QTR_FAST_CYC : QTR_STD_CYC);

    logic sda_f;
    icp_host_st_e st;
    icp_host_st_e next_st;
    icp_stage_e stage;
    icp_stage_e next_stage;
    logic [1:0] q;
    logic [1:0] next_q;
    logic [7:0] qcnt;
    logic [7:0] next_qcnt;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit;
    logic [7:0] txb;
    logic [7:0] next_txb;
    logic [7:0] rxb;
    logic [7:0] next_rxb;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [7:0] len;
    logic [7:0] next_len;
    logic rw;
    logic next_rw;
    logic [7:0] sub;
    logic [7:0] next_sub;
    logic scl_lvl;
    logic sda_lvl;
    logic next_scl;
    logic next_sda;
    logic next_take;
    logic next_rdv;
    logic [7:0] next_rdb;
    logic next_done;
    logic next_nack;
    logic slot_end;
    logic last_rd;

    icp_line_filter u_sda_filt (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .raw(link.sda),
        .level(sda_f)
    );

    assign slot_end = (qcnt == 8'(QTR - 8'h01)) && (q == 2'h3);
    assign last_rd = (8'(cnt + 8'h01) == len);

    // Line levels per quarter of a bit slot
    always_comb begin
        next_scl = 1'b1;
        next_sda = 1'b1;
        case (st)
            H_START: begin
                // R3 data falls while clock high
                next_scl = (q == 2'h1) || (q == 2'h2);
                next_sda = (q < 2'h2);
            end
            H_STOP: begin
                next_scl = q[1];
                next_sda = (q == 2'h3);
            end
            H_TXB: begin
                // R4 data set in the second low quarter
                next_scl = q[1];
                next_sda = bit_cnt[3] ? 1'b1 : txb[7];
            end
            H_RXB: begin
                // R18 NACK on the final byte
                next_scl = q[1];
                next_sda = bit_cnt[3] ? last_rd : 1'b1;
            end
            default: begin
                next_scl = 1'b1;
                next_sda = 1'b1;
            end
        endcase
        // R4 hold data while the clock falls
        if (q == 2'h0) next_sda = sda_lvl;
    end

    always_comb begin
        next_st = st;
        next_stage = stage;
        next_q = q;
        next_qcnt = qcnt;
        next_bit = bit_cnt;
        next_txb = txb;
        next_rxb = rxb;
        next_cnt = cnt;
        next_len = len;
        next_rw = rw;
        next_sub = sub;
        next_take = 1'b0;
        next_rdv = 1'b0;
        next_rdb = rd_byte;
        next_done = 1'b0;
        next_nack = nack;
        if (st == H_IDLE) begin
            next_q = 2'h0;
            next_qcnt = 8'h00;
            if (cmd_valid) begin
                next_st = H_START;
                next_stage = S_DEVW;
                next_rw = cmd_rw;
                next_sub = cmd_sub;
                next_len = cmd_len;
                next_cnt = 8'h00;
                next_nack = 1'b0;
            end
        end else begin
            next_qcnt = (qcnt == 8'(QTR - 8'h01)) ? 8'h00 : 8'(qcnt + 8'h01);
            if (qcnt == 8'(QTR - 8'h01)) begin
                next_q = 2'(q + 2'h1);
            end
        end
        if (slot_end) begin
            case (st)
                H_START: begin
                    // R15 R17 direction bit after address
                    next_st = H_TXB;
                    next_bit = 4'h0;
                    next_txb = {DEV_ADDR, (stage == S_DEVR)};
                end
                H_TXB: begin
                    if (!bit_cnt[3]) begin
                        // R1 MSB first
                        next_txb = {txb[6:0], 1'b0};
                        next_bit = 4'(bit_cnt + 4'h1);
                    end else if (sda_f) begin
                        // R2 missing acknowledge ends the transfer
                        next_nack = 1'b1;
                        next_st = H_STOP;
                    end else begin
                        next_bit = 4'h0;
                        case (stage)
                            S_DEVW: begin
                                next_stage = S_SUB;
                                next_txb = sub;
                            end
                            S_SUB, S_WDATA: begin
                                if (stage == S_WDATA) begin
                                    next_cnt = 8'(cnt + 8'h01);
                                end
                                // R17 restart before reading
                                if (rw && len != 8'h00) begin
                                    next_stage = S_DEVR;
                                    next_st = H_START;
                                end else if (rw ||
                                    8'(next_cnt) == len) begin
                                    next_st = H_STOP;
                                end else begin
                                    // R8 byte count set by caller
                                    next_stage = S_WDATA;
                                    next_txb = wr_byte;
                                    next_take = 1'b1;
                                end
                            end
                            default: begin
                                next_stage = S_RDATA;
                                next_st = H_RXB;
                            end
                        endcase
                    end
                end
                H_RXB: begin
                    if (!bit_cnt[3]) begin
                        next_rxb = {rxb[6:0], sda_f};
                        next_bit = 4'(bit_cnt + 4'h1);
                    end else begin
                        next_rdv = 1'b1;
                        next_rdb = rxb;
                        next_cnt = 8'(cnt + 8'h01);
                        next_bit = 4'h0;
                        if (last_rd) begin
                            next_st = H_STOP;
                        end
                    end
                end
                H_STOP: begin
                    next_st = H_IDLE;
                    next_done = 1'b1;
                end
                default: begin
                    next_st = H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= H_IDLE;
            stage <= S_DEVW;
            q <= 2'h0;
            qcnt <= 8'h00;
            bit_cnt <= 4'h0;
            txb <= 8'h00;
            rxb <= 8'h00;
            cnt <= 8'h00;
            len <= 8'h00;
            rw <= 1'b0;
            sub <= 8'h00;
            scl_lvl <= 1'b1;
            sda_lvl <= 1'b1;
            wr_take <= 1'b0;
            rd_valid <= 1'b0;
            rd_byte <= 8'h00;
            done <= 1'b0;
            nack <= 1'b0;
        end else if (ce) begin
            st <= next_st;
            stage <= next_stage;
            q <= next_q;
            qcnt <= next_qcnt;
            bit_cnt <= next_bit;
            txb <= next_txb;
            rxb <= next_rxb;
            cnt <= next_cnt;
            len <= next_len;
            rw <= next_rw;
            sub <= next_sub;
            scl_lvl <= next_scl;
            sda_lvl <= next_sda;
            wr_take <= next_take;
            rd_valid <= next_rdv;
            rd_byte <= next_rdb;
            done <= next_done;
            nack <= next_nack;
        end
    end

    assign cmd_ready = (st == H_IDLE);
    // Open drain: a high level is released, never driven
    assign link.host_scl_o = 1'b0;
    assign link.host_scl_oe = ~scl_lvl;
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe = ~sda_lvl;
endmodule : icp_host_end

// ### tb/icp_properties.sv
// Bus-level checks on the two-wire control link
`timescale 1ns/10ps
module icp_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic host_scl_o,
    input wire logic host_scl_oe,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic scl_q;
    logic [7:0] run;
    logic [7:0] next_run;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Cycles the clock line has stood still, saturating
    always_comb begin
        next_run = (run == 8'hFF) ? run : run + 8'h01;
        if (scl != scl_q) next_run = 8'h00;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run <= 8'hFF;
            scl_q <= 1'b1;
        end else begin
            run <= next_run;
            scl_q <= scl;
        end
    end
    AST_OPEN_DRAIN: assert property (!dev_sda_o && !host_sda_o && !host_scl_o)
        else $error("link driver drives high");
    AST_DEV_MOVE_LOW: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device data moved while clock high");
    AST_ACK_HOLD: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
        else $error("device low pull too short");
    AST_NO_CLASH: assert property (scl && dev_sda_oe |-> !host_sda_oe)
        else $error("both ends pull data in a high clock");
    AST_START_HOLD: assert property (scl && $past(scl) && $fell(sda) |-> scl [*8])
        else $error("clock fell too soon after start");
    AST_STOP_FREE: assert property (scl && $past(scl) && $rose(sda) |-> !dev_sda_oe ##1 sda [*8])
        else $error("bus not free after stop");
    AST_SCL_PHASE: assert property ($changed(scl) |-> run >= 8'h1C)
        else $error("clock phase shorter than allowed");
    AST_RESET_IDLE: assert property ($rose(rst_n) |-> !dev_sda_oe && !host_sda_oe && !host_scl_oe)
        else $error("bus not released after reset");
    cover property (scl && $past(scl) && $fell(sda));
    cover property ($rose(dev_sda_oe));
    cover property (scl && $past(scl) && $rose(sda));
endmodule : icp_properties

// ### tb/i2c_control_slave_port_tb.sv
// Self-checking bench joining both ends of the control port
`timescale 1ns/10ps
module i2c_control_slave_port_tb;
    import icp_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce_h = 1'b1;
    logic ce_d = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_rw = 1'b0;
    logic [7:0] cmd_sub = 8'h00, cmd_len = 8'h00, wr_byte = 8'h00;
    logic cmd_ready, wr_take, rd_valid, done, nack, wr_commit;
    logic [7:0] rd_byte, reg_addr, wr_addr;
    logic [4:0] wr_nbytes;
    logic [MAX_BYTES*BYTE_W-1:0] wr_data, mask;
    logic [31:0] mem [256];
    logic [7:0] txq [$], erd [$], eaddr [$];
    logic [159:0] edat [$];
    int err_count = 0, n_compared = 0, seed = 7604, cyc = 0;
    icp_link_if link ();
    always #10 clk = ~clk;
    function automatic int sz(input logic [7:0] a);
        return (a >= 8'h20) ? 20 : (a >= 8'h10) ? 4 : 1;
    endfunction : sz
    icp_host_end #(.FAST(1'b1)) u_icp_host_end (.clk(clk), .rst_n(rst_n),
        .ce(ce_h), .link(link.host), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_rw(cmd_rw), .cmd_sub(cmd_sub),
        .cmd_len(cmd_len), .wr_byte(wr_byte), .wr_take(wr_take),
        .rd_valid(rd_valid), .rd_byte(rd_byte), .done(done), .nack(nack));
    icp_dev_end u_icp_dev_end (.clk(clk), .rst_n(rst_n), .ce(ce_d),
        .link(link.dev), .reg_addr(reg_addr),
        .size_bytes(5'(sz(reg_addr))), .rd_word(), .rd_data(mem[reg_addr]),
        .wr_commit(wr_commit), .wr_addr(wr_addr), .wr_nbytes(wr_nbytes),
        .wr_data(wr_data));
    icp_properties u_props (.clk(clk), .rst_n(rst_n),
        .host_scl_o(link.host_scl_o), .host_scl_oe(link.host_scl_oe),
        .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
        .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe),
        .scl(link.scl), .sda(link.sda));
    task automatic chk(input string what, input logic [159:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", what, e, g);
        end
    endtask : chk
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // Builds the expected bytes and commits, then runs one command
    task automatic run(input logic rw, input logic [7:0] sub, len);
        int i;
        int k;
        logic [7:0] a;
        logic [7:0] b;
        logic [159:0] d;
        a = sub;
        k = 0;
        d = '0;
        for (i = 0; i < len; i++) begin
            b = rw ? (sz(a) == 1 ? mem[a][7:0] : mem[a][31 - 8 * k -: 8])
                : 8'($random(seed));
            if (rw) erd.push_back(b);
            else txq.push_back(b);
            d = {d[151:0], b};
            k++;
            if (k == sz(a)) begin
                if (!rw) eaddr.push_back(a);
                if (!rw) edat.push_back(d);
                a++;
                k = 0;
                d = '0;
            end
        end
        wr_byte = txq.size() ? txq.pop_front() : 8'h00;
        cmd_rw = rw;
        cmd_sub = sub;
        cmd_len = len;
        cmd_valid = 1'b1;
        @(posedge clk iff ce_h);
        #1 cmd_valid = 1'b0;
        for (i = 0; i < 30000 && done !== 1'b1; i++) begin
            if (wr_take === 1'b1 && txq.size()) wr_byte = txq.pop_front();
            @(posedge clk iff ce_h);
            #1;
        end
        chk("done", 1, done);
        chk("nack", 0, nack);
        chk("pending", 0, eaddr.size() + erd.size());
        txq.delete();
        edat.delete();
    endtask : run
    always @(negedge clk) begin
        if (wr_commit === 1'b1 && ce_d) begin
            mask = ~({160{1'b1}} << (8 * wr_nbytes));
            chk("commit size", sz(eaddr[0]), wr_nbytes);
            chk("commit addr", eaddr.pop_front(), wr_addr);
            chk("commit data", edat.pop_front(), wr_data & mask);
        end
        if (rd_valid === 1'b1 && ce_h)
            chk("read byte", erd.pop_front(), rd_byte);
    end
    // Random enable gaps stretch both ends independently
    always @(posedge clk) begin
        #1 ce_h = ($random(seed) & 7) != 0;
        ce_d = ($random(seed) & 7) != 0;
        cyc++;
        if (cyc > 90000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        foreach (mem[j]) mem[j] = $random(seed);
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        run(1'b0, 8'h05, 8'd1);
        run(1'b0, 8'h0E, 8'd6);
        run(1'b0, 8'h1F, 8'd10);
        run(1'b1, 8'h0E, 8'd7);
        final_report();
    end
endmodule : i2c_control_slave_port_tb
